/* verilog/ssr_pkg.sv */
//==============================================================
// Status reporting register set: shared constants and types
//==============================================================
package ssr_pkg;

    //==========================================================
    // Widths
    //==========================================================
    localparam int unsigned REG_W = 16;
    localparam int unsigned STB_W = 8;

    //==========================================================
    // Operation bit positions
    //==========================================================
    localparam int unsigned OP_SETTLING_BIT  = 1;
    localparam int unsigned OP_TRIG_WAIT_BIT = 5;
    localparam int unsigned OP_TRAN_PRIM_BIT = 6;
    localparam int unsigned OP_CONST_V_BIT   = 8;
    localparam int unsigned OP_TRAN_DONE_BIT = 9;
    localparam int unsigned OP_CONST_I_BIT   = 10;
    localparam int unsigned OP_SAMPLE_BIT    = 11;
    localparam int unsigned OP_LIST_DONE_BIT = 12;
    localparam int unsigned OP_LIST_ACT_BIT  = 14;

    //==========================================================
    // Questionable bit positions
    //==========================================================
    localparam int unsigned QS_VMODE_BIT   = 0;
    localparam int unsigned QS_IMODE_BIT   = 1;
    localparam int unsigned QS_THERMAL_BIT = 3;
    localparam int unsigned QS_FOLLOW_BIT  = 6;
    localparam int unsigned QS_VFAULT_BIT  = 12;
    localparam int unsigned QS_IFAULT_BIT  = 13;
    localparam int unsigned QS_ABSORB_BIT  = 14;

    //==========================================================
    // Masks and reset / preset values
    //==========================================================
    localparam logic [REG_W-1:0] OPER_USED_MASK  = 16'h5f62;
    localparam logic [REG_W-1:0] QUES_USED_MASK  = 16'h704b;
    localparam logic [REG_W-1:0] QUES_LATCH_MASK = 16'h3000;
    localparam logic [REG_W-1:0] OPER_ENAB_RST   = 16'h0000;
    localparam logic [REG_W-1:0] QUES_ENAB_RST   = 16'h0000;
    localparam logic [REG_W-1:0] OPER_ENAB_PRES  = 16'h2001;
    localparam logic [REG_W-1:0] QUES_ENAB_PRES  = 16'h00ff;
    localparam logic [REG_W-1:0] REG_ZERO        = 16'h0000;

    //==========================================================
    // Status byte summary positions
    //==========================================================
    localparam int unsigned STB_OPER_BIT = 7;
    localparam int unsigned STB_QUES_BIT = 3;

    //==========================================================
    // Command port types
    //==========================================================
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_PRESET,
        OP_NONE
    } ssr_op_t;

    typedef enum logic [2:0] {
        SEL_OPER_COND,
        SEL_OPER_ENAB,
        SEL_OPER_EVENT,
        SEL_QUES_EVENT,
        SEL_QUES_COND,
        SEL_QUES_ENAB,
        SEL_SPARE0,
        SEL_SPARE1
    } ssr_sel_t;

    typedef struct packed {
        logic              valid;
        ssr_op_t           op;
        ssr_sel_t          sel;
        logic [REG_W-1:0]  wdata;
    } ssr_cmd_t;

    // Operating condition flags
    typedef struct packed {
        logic const_voltage_flag;
        logic const_current_flag;
        logic list_done_flag;
        logic list_active_flag;
        logic sample_done_flag;
        logic transient_done_flag;
        logic transient_primed_flag;
        logic trigger_wait_flag;
        logic settling_flag;
    } ssr_oper_flags_t;

    // Questionable condition flags
    typedef struct packed {
        logic energy_absorb_flag;
        logic current_fault_flag;
        logic voltage_fault_flag;
        logic follower_fault_flag;
        logic thermal_fault_flag;
        logic current_mode_fault_flag;
        logic voltage_mode_fault_flag;
    } ssr_ques_flags_t;

endpackage : ssr_pkg

/* verilog/ssr_event_group.sv */
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// One status group: edge latch, clear on read, summary
//==============================================================
module ssr_event_group #(
    parameter int unsigned               WIDTH         = 16,
    parameter logic [WIDTH-1:0]          LATCH_MASK    = '1,
    parameter bit                        GATE_BY_MASK  = 1'b0
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    // Live condition and mask
    input  wire logic [WIDTH-1:0]        cond_in,
    input  wire logic [WIDTH-1:0]        mask_in,
    // Clear strobe from a read
    input  wire logic                    clear_in,
    // Latched events and summary
    output logic      [WIDTH-1:0]        event_out,
    output logic                         summary_out
);

    logic [WIDTH-1:0] cond_prev;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] set_bits;
    logic [WIDTH-1:0] next_event;

    // Previous condition for edge detect
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            cond_prev <= '0;
        else
            cond_prev <= cond_in;
    end

    // Inactive to active transitions on latchable bits
    always_comb
    begin
        rise = cond_in & ~cond_prev;
        if (GATE_BY_MASK)
            set_bits = rise & LATCH_MASK & mask_in;
        else
            set_bits = rise & LATCH_MASK;
        next_event = (event_out & ~{WIDTH{clear_in}}) | set_bits;
    end

    // Latched event register, set wins over clear
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            event_out <= '0;
        else
            event_out <= next_event;
    end

    // Summary follows event and mask directly
    assign summary_out = |(event_out & mask_in);

endmodule : ssr_event_group
`default_nettype wire

/* verilog/ssr_status_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Operation live-state read returns current operating conditions, never latched.
// - Operation bits: constant voltage 8, constant current 10, list done 12, list active 14.
// - Sample done 11, transient done 9, primed 6, trigger wait 5, settling 1.
// - Writable operation mask; a one lets that event bit reach the summary.
// - Status byte bit 7 is OR of masked operation event bits.
// - Reading the operation mask returns the stored value unchanged.
// - Operation event register is read-only and holds events until read.
// - Reading the operation event register returns its value, then clears it.
// - Preset loads operation mask with 8193 and questionable mask with 255.
// - Questionable bits: absorb 14, current 13, voltage 12, follower 6, thermal 3, modes 1/0.
// - Only questionable bits 13 and 12 latch; bits 1 and 0 never latch.
// - Reading questionable events returns them and clears; software cannot write them.
// - Questionable live-state read shows active conditions as ones, unlatched.
// - Questionable bits 1 and 0 both set while the output is settling.
// - Status byte bit 3 is OR of masked questionable event bits.
// - Writable questionable mask gates which conditions latch into its event register.
module ssr_status_regs #(
    parameter int unsigned                       REG_W = ssr_pkg::REG_W
) (
    // Clock and reset
    input  wire logic                            CLK_IN,
    input  wire logic                            RST_N_IN,
    // Command port
    input  wire ssr_pkg::ssr_cmd_t               CMD_IN,
    // Live condition flags
    input  wire ssr_pkg::ssr_oper_flags_t        OPER_FLAGS_IN,
    input  wire ssr_pkg::ssr_ques_flags_t        QUES_FLAGS_IN,
    // Read answer
    output logic      [REG_W-1:0]                RD_DATA_OUT,
    output logic                                 RD_VALID_OUT,
    output logic                                 CMD_ERROR_OUT,
    // Status byte summaries
    output logic      [ssr_pkg::STB_W-1:0]       STATUS_BYTE_OUT,
    output logic                                 OPER_SUMMARY_OUT,
    output logic                                 QUES_SUMMARY_OUT
);

    //==========================================================
    // Declarations
    //==========================================================
    logic [REG_W-1:0] oper_cond;
    logic [REG_W-1:0] ques_cond;
    logic [REG_W-1:0] oper_enab;
    logic [REG_W-1:0] ques_enab;
    logic [REG_W-1:0] oper_event;
    logic [REG_W-1:0] ques_event;
    logic             oper_sum;
    logic             ques_sum;
    logic             cmd_read;
    logic             cmd_write;
    logic             cmd_preset;
    logic             clr_oper;
    logic             clr_ques;
    logic             wr_oper_enab;
    logic             wr_ques_enab;
    logic [REG_W-1:0] next_rd_data;
    logic             next_error;

    //==========================================================
    // Decode helpers
    //==========================================================
    // Register selects that software may write
    function automatic logic sel_writable(input ssr_pkg::ssr_sel_t sel);
        case (sel)
            ssr_pkg::SEL_OPER_ENAB: sel_writable = 1'b1;
            ssr_pkg::SEL_QUES_ENAB: sel_writable = 1'b1;
            default:                sel_writable = 1'b0;
        endcase
    endfunction : sel_writable

    // Register selects that map to a register
    function automatic logic sel_mapped(input ssr_pkg::ssr_sel_t sel);
        case (sel)
            ssr_pkg::SEL_OPER_COND:  sel_mapped = 1'b1;
            ssr_pkg::SEL_OPER_ENAB:  sel_mapped = 1'b1;
            ssr_pkg::SEL_OPER_EVENT: sel_mapped = 1'b1;
            ssr_pkg::SEL_QUES_EVENT: sel_mapped = 1'b1;
            ssr_pkg::SEL_QUES_COND:  sel_mapped = 1'b1;
            ssr_pkg::SEL_QUES_ENAB:  sel_mapped = 1'b1;
            default:                 sel_mapped = 1'b0;
        endcase
    endfunction : sel_mapped

    //==========================================================
    // Operation condition assembly
    //==========================================================
    // Live flags placed at their bit positions, unused bits zero
    always_comb
    begin
        oper_cond = ssr_pkg::REG_ZERO;
        oper_cond[ssr_pkg::OP_CONST_V_BIT]   = OPER_FLAGS_IN.const_voltage_flag;
        oper_cond[ssr_pkg::OP_CONST_I_BIT]   = OPER_FLAGS_IN.const_current_flag;
        oper_cond[ssr_pkg::OP_LIST_DONE_BIT] = OPER_FLAGS_IN.list_done_flag;
        oper_cond[ssr_pkg::OP_LIST_ACT_BIT]  = OPER_FLAGS_IN.list_active_flag;
        oper_cond[ssr_pkg::OP_SAMPLE_BIT]    = OPER_FLAGS_IN.sample_done_flag;
        oper_cond[ssr_pkg::OP_TRAN_DONE_BIT] = OPER_FLAGS_IN.transient_done_flag;
        oper_cond[ssr_pkg::OP_TRAN_PRIM_BIT] = OPER_FLAGS_IN.transient_primed_flag;
        oper_cond[ssr_pkg::OP_TRIG_WAIT_BIT] = OPER_FLAGS_IN.trigger_wait_flag;
        oper_cond[ssr_pkg::OP_SETTLING_BIT]  = OPER_FLAGS_IN.settling_flag;
    end

    //==========================================================
    // Questionable condition assembly
    //==========================================================
    // Mode error bits also raised together while settling
    always_comb
    begin
        ques_cond = ssr_pkg::REG_ZERO;
        ques_cond[ssr_pkg::QS_ABSORB_BIT]  = QUES_FLAGS_IN.energy_absorb_flag;
        ques_cond[ssr_pkg::QS_IFAULT_BIT]  = QUES_FLAGS_IN.current_fault_flag;
        ques_cond[ssr_pkg::QS_VFAULT_BIT]  = QUES_FLAGS_IN.voltage_fault_flag;
        ques_cond[ssr_pkg::QS_FOLLOW_BIT]  = QUES_FLAGS_IN.follower_fault_flag;
        ques_cond[ssr_pkg::QS_THERMAL_BIT] = QUES_FLAGS_IN.thermal_fault_flag;
        ques_cond[ssr_pkg::QS_IMODE_BIT]   = QUES_FLAGS_IN.current_mode_fault_flag
                                           | OPER_FLAGS_IN.settling_flag;
        ques_cond[ssr_pkg::QS_VMODE_BIT]   = QUES_FLAGS_IN.voltage_mode_fault_flag
                                           | OPER_FLAGS_IN.settling_flag;
    end

    //==========================================================
    // Command decode
    //==========================================================
    // One command per cycle when valid
    always_comb
    begin
        cmd_read   = CMD_IN.valid && (CMD_IN.op == ssr_pkg::OP_READ);
        cmd_write  = CMD_IN.valid && (CMD_IN.op == ssr_pkg::OP_WRITE);
        cmd_preset = CMD_IN.valid && (CMD_IN.op == ssr_pkg::OP_PRESET);
        clr_oper   = cmd_read && (CMD_IN.sel == ssr_pkg::SEL_OPER_EVENT);
        clr_ques   = cmd_read && (CMD_IN.sel == ssr_pkg::SEL_QUES_EVENT);
        wr_oper_enab = cmd_write && (CMD_IN.sel == ssr_pkg::SEL_OPER_ENAB);
        wr_ques_enab = cmd_write && (CMD_IN.sel == ssr_pkg::SEL_QUES_ENAB);
    end

    //==========================================================
    // Enable masks
    //==========================================================
    // Operation mask: write or preset, all written bits stored, unused ones included
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            oper_enab <= ssr_pkg::OPER_ENAB_RST;
        else if (cmd_preset)
            oper_enab <= ssr_pkg::OPER_ENAB_PRES;
        else if (wr_oper_enab)
            oper_enab <= CMD_IN.wdata;
    end

    // Questionable mask: write or preset
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            ques_enab <= ssr_pkg::QUES_ENAB_RST;
        else if (cmd_preset)
            ques_enab <= ssr_pkg::QUES_ENAB_PRES;
        else if (wr_ques_enab)
            ques_enab <= CMD_IN.wdata;
    end

    //==========================================================
    // Event groups
    //==========================================================
    // Operation group latches every used bit
    ssr_event_group #(
        .WIDTH        (REG_W),
        .LATCH_MASK   (ssr_pkg::OPER_USED_MASK),
        .GATE_BY_MASK (1'b0)
    ) u_oper_group (
        .clk_in      (CLK_IN),
        .rst_n_in    (RST_N_IN),
        .cond_in     (oper_cond),
        .mask_in     (oper_enab),
        .clear_in    (clr_oper),
        .event_out   (oper_event),
        .summary_out (oper_sum)
    );

    // Questionable group latches only the current and voltage fault bits 13 and 12, gated by its mask
    ssr_event_group #(
        .WIDTH        (REG_W),
        .LATCH_MASK   (ssr_pkg::QUES_LATCH_MASK),
        .GATE_BY_MASK (1'b1)
    ) u_ques_group (
        .clk_in      (CLK_IN),
        .rst_n_in    (RST_N_IN),
        .cond_in     (ques_cond),
        .mask_in     (ques_enab),
        .clear_in    (clr_ques),
        .event_out   (ques_event),
        .summary_out (ques_sum)
    );

    //==========================================================
    // Read multiplexer
    //==========================================================
    // Value captured before any clear at the same edge
    always_comb
    begin
        next_rd_data = ssr_pkg::REG_ZERO;
        case (CMD_IN.sel)
            ssr_pkg::SEL_OPER_COND:  next_rd_data = oper_cond;
            ssr_pkg::SEL_OPER_ENAB:  next_rd_data = oper_enab;
            ssr_pkg::SEL_OPER_EVENT: next_rd_data = oper_event;
            ssr_pkg::SEL_QUES_EVENT: next_rd_data = ques_event;
            ssr_pkg::SEL_QUES_COND:  next_rd_data = ques_cond;
            ssr_pkg::SEL_QUES_ENAB:  next_rd_data = ques_enab;
            default:                 next_rd_data = ssr_pkg::REG_ZERO;
        endcase
    end

    // Errors: unmapped select, write to a read-only register, or a valid OP_NONE command
    always_comb
    begin
        next_error = 1'b0;
        if (cmd_read && !sel_mapped(CMD_IN.sel))
            next_error = 1'b1;
        if (cmd_write && !sel_writable(CMD_IN.sel))
            next_error = 1'b1;
        if (CMD_IN.valid && (CMD_IN.op == ssr_pkg::OP_NONE))
            next_error = 1'b1;
    end

    // Registered read data
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            RD_DATA_OUT <= ssr_pkg::REG_ZERO;
        else if (cmd_read)
            RD_DATA_OUT <= next_rd_data;
    end

    // Read answer strobe, one cycle after the command
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            RD_VALID_OUT <= 1'b0;
        else
            RD_VALID_OUT <= cmd_read;
    end

    // Error strobe, one cycle after the command
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            CMD_ERROR_OUT <= 1'b0;
        else
            CMD_ERROR_OUT <= next_error;
    end

    //==========================================================
    // Status byte
    //==========================================================
    // Summaries follow events and masks in the same cycle
    always_comb
    begin
        STATUS_BYTE_OUT = '0;
        STATUS_BYTE_OUT[ssr_pkg::STB_OPER_BIT] = oper_sum;
        STATUS_BYTE_OUT[ssr_pkg::STB_QUES_BIT] = ques_sum;
    end

    assign OPER_SUMMARY_OUT = oper_sum;
    assign QUES_SUMMARY_OUT = ques_sum;

endmodule : ssr_status_regs
`default_nettype wire

/* bench/ssr_status_regs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// Port checker for the status reporting register set
//==============================================================
module ssr_status_regs_monitor #(
    parameter int unsigned                REG_W = 16
) (
    // Clock and reset
    input  wire logic                     CLK_IN,
    input  wire logic                     RST_N_IN,
    // Command and live flags
    input  wire ssr_pkg::ssr_cmd_t        CMD_IN,
    input  wire ssr_pkg::ssr_oper_flags_t OPER_FLAGS_IN,
    input  wire ssr_pkg::ssr_ques_flags_t QUES_FLAGS_IN,
    // Answers and summaries
    input  wire logic [REG_W-1:0]         RD_DATA_OUT,
    input  wire logic                     RD_VALID_OUT,
    input  wire logic                     CMD_ERROR_OUT,
    input  wire logic [ssr_pkg::STB_W-1:0] STATUS_BYTE_OUT,
    input  wire logic                     OPER_SUMMARY_OUT,
    input  wire logic                     QUES_SUMMARY_OUT
);
    //==========================================================
    // Expected live-state words
    //==========================================================
    // Operation word from the flag struct
    function automatic logic [15:0] oper_word(ssr_pkg::ssr_oper_flags_t f);
        return {1'h0, f.list_active_flag, 1'h0, f.list_done_flag, f.sample_done_flag, f.const_current_flag,
                f.transient_done_flag, f.const_voltage_flag, 1'h0, f.transient_primed_flag,
                f.trigger_wait_flag, 3'h0, f.settling_flag, 1'h0};
    endfunction : oper_word

    // Questionable word; settling raises both mode bits
    function automatic logic [15:0] ques_word(ssr_pkg::ssr_ques_flags_t q, logic s);
        return {1'h0, q.energy_absorb_flag, q.current_fault_flag, q.voltage_fault_flag, 5'h00,
                q.follower_fault_flag, 2'h0, q.thermal_fault_flag, 1'h0,
                q.current_mode_fault_flag | s, q.voltage_mode_fault_flag | s};
    endfunction : ques_word

    //==========================================================
    // Command decode and assertions
    //==========================================================
    // Decoded command strobes
    logic rd_op;
    logic wr_op;
    assign rd_op = CMD_IN.valid && CMD_IN.op == ssr_pkg::OP_READ;
    assign wr_op = CMD_IN.valid && CMD_IN.op == ssr_pkg::OP_WRITE;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    chk_oper_cond_live: assert property (rd_op && CMD_IN.sel == ssr_pkg::SEL_OPER_COND
        |=> RD_VALID_OUT && RD_DATA_OUT == oper_word($past(OPER_FLAGS_IN)))
        else $error("operation live-state read mismatch");
    chk_ques_cond_live: assert property (rd_op && CMD_IN.sel == ssr_pkg::SEL_QUES_COND
        |=> RD_DATA_OUT == ques_word($past(QUES_FLAGS_IN), $past(OPER_FLAGS_IN.settling_flag)))
        else $error("questionable live-state read mismatch");
    chk_mask_readback: assert property ((wr_op && CMD_IN.sel == ssr_pkg::SEL_OPER_ENAB) ##1
        (rd_op && CMD_IN.sel == ssr_pkg::SEL_OPER_ENAB) |=> RD_DATA_OUT == $past(CMD_IN.wdata, 2))
        else $error("operation mask readback mismatch");
    chk_preset_load: assert property ((CMD_IN.valid && CMD_IN.op == ssr_pkg::OP_PRESET) ##1
        (rd_op && CMD_IN.sel == ssr_pkg::SEL_OPER_ENAB) |=> RD_DATA_OUT == 16'h2001)
        else $error("preset operation mask wrong");
    chk_oper_clear: assert property (rd_op && CMD_IN.sel == ssr_pkg::SEL_OPER_EVENT && $past(RST_N_IN)
        && (OPER_FLAGS_IN & ~$past(OPER_FLAGS_IN)) == '0 |=> !OPER_SUMMARY_OUT)
        else $error("operation events not cleared by read");
    chk_ques_clear: assert property (rd_op && CMD_IN.sel == ssr_pkg::SEL_QUES_EVENT && $past(RST_N_IN)
        && (QUES_FLAGS_IN & ~$past(QUES_FLAGS_IN)) == '0 |=> !QUES_SUMMARY_OUT)
        else $error("questionable events not cleared by read");
    chk_event_keep: assert property ((rd_op && CMD_IN.sel == ssr_pkg::SEL_OPER_EVENT && $past(RST_N_IN)
        && $rose(OPER_FLAGS_IN.const_current_flag)) ##1 (rd_op && CMD_IN.sel == ssr_pkg::SEL_OPER_EVENT)
        |=> RD_DATA_OUT[10])
        else $error("event lost under clear");
    chk_ques_latch: assert property (rd_op && CMD_IN.sel == ssr_pkg::SEL_QUES_EVENT
        |=> RD_VALID_OUT && (RD_DATA_OUT & 16'hcfff) == 16'h0000)
        else $error("questionable event outside bits 13 and 12");
    chk_ro_write: assert property (wr_op && CMD_IN.sel inside {ssr_pkg::SEL_OPER_EVENT, ssr_pkg::SEL_QUES_EVENT}
        |=> CMD_ERROR_OUT && RD_DATA_OUT == $past(RD_DATA_OUT))
        else $error("event register write not refused");
    chk_stb_layout: assert property (STATUS_BYTE_OUT == {OPER_SUMMARY_OUT, 3'h0, QUES_SUMMARY_OUT, 3'h0})
        else $error("status byte layout wrong");
    chk_mask_off: assert property (wr_op && CMD_IN.sel == ssr_pkg::SEL_OPER_ENAB && CMD_IN.wdata == 16'h0000
        |=> !OPER_SUMMARY_OUT)
        else $error("cleared mask leaves summary set");

    // Main scenarios reached
    cov_event_read: cover property (rd_op && CMD_IN.sel == ssr_pkg::SEL_OPER_EVENT ##1 RD_DATA_OUT != 16'h0000);
    cov_ques_sum: cover property (QUES_SUMMARY_OUT);
    cov_refused: cover property (CMD_ERROR_OUT);
endmodule : ssr_status_regs_monitor

bind ssr_status_regs ssr_status_regs_monitor #(.REG_W(REG_W)) i_mon (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CMD_IN(CMD_IN),
    .OPER_FLAGS_IN(OPER_FLAGS_IN), .QUES_FLAGS_IN(QUES_FLAGS_IN),
    .RD_DATA_OUT(RD_DATA_OUT), .RD_VALID_OUT(RD_VALID_OUT), .CMD_ERROR_OUT(CMD_ERROR_OUT),
    .STATUS_BYTE_OUT(STATUS_BYTE_OUT), .OPER_SUMMARY_OUT(OPER_SUMMARY_OUT),
    .QUES_SUMMARY_OUT(QUES_SUMMARY_OUT)
);
`default_nettype wire

/* bench/ssr_status_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// Self-checking bench for the status reporting register set
//==============================================================
module ssr_status_regs_bench;
    // One row: command, live flags, expected answer
    typedef struct packed {
        logic        v;
        logic [1:0]  op;
        logic [2:0]  sel;
        logic [15:0] wd;
        logic [8:0]  ofl;
        logic [6:0]  qfl;
        logic [15:0] rd;
        logic        err;
        logic [7:0]  stb;
    } ssr_row_t;

    logic                     clk = 1'h0;
    logic                     rst_n;
    ssr_pkg::ssr_cmd_t        cmd;
    ssr_pkg::ssr_oper_flags_t oper_flags;
    ssr_pkg::ssr_ques_flags_t ques_flags;
    logic [15:0]              rd_data;
    logic                     rd_valid;
    logic                     cmd_error;
    logic [7:0]               status_byte;
    int                       errors = 0;
    int                       num_checks = 0;
    ssr_row_t                 rows [20];
    int                       opos [9];

    ssr_status_regs i_dut (
        .CLK_IN           (clk),
        .RST_N_IN         (rst_n),
        .CMD_IN           (cmd),
        .OPER_FLAGS_IN    (oper_flags),
        .QUES_FLAGS_IN    (ques_flags),
        .RD_DATA_OUT      (rd_data),
        .RD_VALID_OUT     (rd_valid),
        .CMD_ERROR_OUT    (cmd_error),
        .STATUS_BYTE_OUT  (status_byte),
        .OPER_SUMMARY_OUT (),
        .QUES_SUMMARY_OUT ()
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Present one command for one cycle, from a falling edge
    task automatic step(input logic v, input logic [1:0] op, input logic [2:0] sel, input logic [15:0] wd);
        cmd = '{v, ssr_pkg::ssr_op_t'(op), ssr_pkg::ssr_sel_t'(sel), wd};
        @(negedge clk);
    endtask : step

    // Counts and verdict
    task automatic give_verdict();
        $display("Checks: %0d, mismatches: %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Watchdog against a hang
    initial
    begin
        #20000;
        errors++;
        $display("Error at %0t: timeout", $time);
        give_verdict();
    end

    // Main sequence
    initial
    begin
        rst_n = 1'h0;
        cmd = '0;
        oper_flags = '0;
        ques_flags = '0;
        opos = '{8, 10, 12, 14, 11, 9, 6, 5, 1};
        rows = '{
            '{1'h1,2'h0,3'h0,16'h0000,9'h100,7'h00,16'h0100,1'h0,8'h00},
            '{1'h1,2'h1,3'h1,16'h0500,9'h100,7'h00,16'h0100,1'h0,8'h80},
            '{1'h1,2'h0,3'h1,16'h0000,9'h100,7'h00,16'h0500,1'h0,8'h80},
            '{1'h1,2'h0,3'h2,16'h0000,9'h080,7'h00,16'h0100,1'h0,8'h80},
            '{1'h1,2'h0,3'h2,16'h0000,9'h080,7'h00,16'h0400,1'h0,8'h00},
            '{1'h1,2'h0,3'h0,16'h0000,9'h1ff,7'h00,16'h5f62,1'h0,8'h80},
            '{1'h1,2'h1,3'h1,16'h0000,9'h1ff,7'h00,16'h5f62,1'h0,8'h00},
            '{1'h1,2'h1,3'h5,16'h3000,9'h1ff,7'h00,16'h5f62,1'h0,8'h00},
            '{1'h1,2'h0,3'h4,16'h0000,9'h1ff,7'h7f,16'h704b,1'h0,8'h08},
            '{1'h1,2'h0,3'h3,16'h0000,9'h1ff,7'h7f,16'h3000,1'h0,8'h00},
            '{1'h1,2'h2,3'h0,16'h0000,9'h000,7'h00,16'h3000,1'h0,8'h00},
            '{1'h1,2'h0,3'h1,16'h0000,9'h000,7'h00,16'h2001,1'h0,8'h00},
            '{1'h1,2'h0,3'h5,16'h0000,9'h000,7'h00,16'h00ff,1'h0,8'h00},
            '{1'h1,2'h1,3'h2,16'hffff,9'h000,7'h00,16'h00ff,1'h1,8'h00},
            '{1'h1,2'h1,3'h3,16'hffff,9'h000,7'h00,16'h00ff,1'h1,8'h00},
            '{1'h1,2'h3,3'h0,16'h0000,9'h000,7'h00,16'h00ff,1'h1,8'h00},
            '{1'h1,2'h0,3'h2,16'h0000,9'h001,7'h00,16'h5b62,1'h0,8'h00},
            '{1'h1,2'h0,3'h4,16'h0000,9'h001,7'h10,16'h1003,1'h0,8'h00},
            '{1'h1,2'h0,3'h3,16'h0000,9'h001,7'h10,16'h0000,1'h0,8'h00},
            '{1'h1,2'h0,3'h2,16'h0000,9'h001,7'h10,16'h0002,1'h0,8'h00}};
        repeat (5) @(negedge clk);
        rst_n = 1'h1;
        foreach (rows[i])
        begin
            oper_flags = rows[i].ofl;
            ques_flags = rows[i].qfl;
            step(rows[i].v, rows[i].op, rows[i].sel, rows[i].wd);
            check(rd_data, rows[i].rd);
            check({15'h0000, rd_valid}, {15'h0000, rows[i].v && rows[i].op == 2'h0});
            check({15'h0000, cmd_error}, {15'h0000, rows[i].err});
            check({8'h00, status_byte}, {8'h00, rows[i].stb});
        end
        $display("Table test done");
        // Each operation flag alone lands at its own bit
        foreach (opos[i])
        begin
            oper_flags = 9'h100 >> i;
            step(1'h1, 2'h0, 3'h0, 16'h0000);
            check(rd_data, 16'h0001 << opos[i]);
        end
        $display("Bit position test done");
        // Unmapped select reads zero and flags an error
        step(1'h1, 2'h0, 3'h6, 16'h0000);
        check({cmd_error, rd_data[14:0]}, 16'h8000);
        $display("Spare select test done");
        // Mid-run reset clears the operation mask and operation events
        oper_flags = 9'h1ff;
        step(1'h1, 2'h1, 3'h1, 16'hffff);
        check({8'h00, status_byte}, 16'h0080);
        rst_n = 1'h0;
        oper_flags = 9'h000;
        step(1'h0, 2'h3, 3'h0, 16'h0000);
        rst_n = 1'h1;
        step(1'h1, 2'h0, 3'h1, 16'h0000);
        check(rd_data, 16'h0000);
        step(1'h1, 2'h0, 3'h2, 16'h0000);
        check(rd_data, 16'h0000);
        check({8'h00, status_byte}, 16'h0000);
        $display("Reset test done");
        give_verdict();
    end
endmodule : ssr_status_regs_bench
`default_nettype wire
